// >>> hdl/dual_clock_bidir_fifo_pair.sv
// Bidirectional queue pair with mailboxes, parity and port-two bus sizing
`timescale 1ns/1ps
module dual_clock_bidir_fifo_pair (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_side_one_clock,
	input wire logic i_side_one_select_n,
	input wire logic i_side_one_enable,
	input wire logic i_side_one_write,
	input wire logic i_side_one_mailbox,
	input wire logic i_side_one_parity_gen,
	input wire logic [dual_fifo_pkg::DATA_W-1:0] i_side_one_bus,
	output logic [dual_fifo_pkg::DATA_W-1:0] o_side_one_bus,
	output logic o_side_one_bus_oe_n,
	input wire logic i_side_two_clock,
	input wire logic i_side_two_select_n,
	input wire logic i_side_two_enable,
	input wire logic i_side_two_write,
	input wire logic [1:0] i_side_two_size,
	input wire logic [1:0] i_side_two_swap,
	input wire logic i_endian_select,
	input wire logic i_side_two_parity_gen,
	input wire logic [dual_fifo_pkg::DATA_W-1:0] i_side_two_bus,
	output logic [dual_fifo_pkg::DATA_W-1:0] o_side_two_bus,
	output logic o_side_two_bus_oe_n,
	input wire logic i_odd_even,
	input wire logic i_offset_select_lo,
	input wire logic i_offset_select_hi,
	output logic o_side_one_full_flag,
	output logic o_side_one_almost_full,
	output logic o_side_one_empty_flag,
	output logic o_side_one_almost_empty,
	output logic o_side_two_full_flag,
	output logic o_side_two_almost_full,
	output logic o_side_two_empty_flag,
	output logic o_side_two_almost_empty,
	output logic o_mail_one_flag,
	output logic o_mail_two_flag,
	output logic o_side_one_parity_err_n,
	output logic o_side_two_parity_err_n
);
	import dual_fifo_pkg::*;

	logic [41:0] a_s1_r, a_s2_r;
	logic [45:0] b_s1_r, b_s2_r;
	logic [2:0] g_s1_r, g_s2_r;
	logic a_clk_s3_r, b_clk_s3_r;
	logic a_sel_n, a_en, a_wr, a_mbx, a_pg, a_edge, a_go;
	logic b_sel_n, b_en, b_wr, b_endian, b_pg, b_edge, b_go;
	logic [1:0] b_size, b_swap;
	logic [DATA_W-1:0] a_data, b_data;
	logic odd;
	logic [2:0] latch_cnt_r;
	logic [LEVEL_W-1:0] offset_r;
	logic [DATA_W-1:0] mail_one_r, mail_two_r;
	logic fwd_push, fwd_in_ready, fwd_pop, fwd_out_valid;
	logic rev_push, rev_in_ready, rev_pop, rev_out_valid;
	logic [DATA_W-1:0] fwd_out_data, rev_out_data, rev_in_data;
	logic [LEVEL_W-1:0] fwd_level, rev_level;
	logic [3:0] a_flag_s1_r, b_flag_s1_r;
	logic [1:0] b_wr_idx_r, b_rd_idx_r;
	logic [DATA_W-1:0] b_asm_r, b_asm_nxt, b_hold_r, b_hold_nxt, b_rd_out;
	logic b_last_wr, b_last_rd, b_first_rd;
	logic [NBYTES-1:0] b_lane_mask;
	logic mail_one_wr, mail_two_wr, mail_one_rd, mail_two_rd, a_q_rd, b_q_rd, b_piece_rd;

	// Every pin crosses two flip-flops before use; the clock pins become edge enables
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			a_s1_r <= SIDE_ONE_SYNC_RST;
			a_s2_r <= SIDE_ONE_SYNC_RST;
			a_clk_s3_r <= 1'b0;
			b_s1_r <= SIDE_TWO_SYNC_RST;
			b_s2_r <= SIDE_TWO_SYNC_RST;
			b_clk_s3_r <= 1'b0;
			g_s1_r <= '0;
			g_s2_r <= '0;
		end else begin
			a_s1_r <= {i_side_one_clock, i_side_one_select_n, i_side_one_enable, i_side_one_write,
				i_side_one_mailbox, i_side_one_parity_gen, i_side_one_bus};
			a_s2_r <= a_s1_r;
			a_clk_s3_r <= a_s2_r[41];
			b_s1_r <= {i_side_two_clock, i_side_two_select_n, i_side_two_enable, i_side_two_write,
				i_side_two_size, i_side_two_swap, i_endian_select, i_side_two_parity_gen, i_side_two_bus};
			b_s2_r <= b_s1_r;
			b_clk_s3_r <= b_s2_r[45];
			g_s1_r <= {i_odd_even, i_offset_select_hi, i_offset_select_lo};
			g_s2_r <= g_s1_r;
		end
	end

	assign {a_sel_n, a_en, a_wr, a_mbx, a_pg, a_data} = a_s2_r[40:0];
	assign {b_sel_n, b_en, b_wr, b_size, b_swap, b_endian, b_pg, b_data} = b_s2_r[44:0];
	assign odd = g_s2_r[2];
	// Each port has its own edge enable; nothing assumes a relation between them
	assign a_edge = a_s2_r[41] & ~a_clk_s3_r;
	assign b_edge = b_s2_r[45] & ~b_clk_s3_r;
	assign a_go = a_edge & ~a_sel_n & a_en;
	assign b_go = b_edge & ~b_sel_n & b_en;

	// Offset selects are taken once, after the synchronisers have refilled
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			latch_cnt_r <= '0;
			offset_r <= OFFSET_SEL0;
		end else if (latch_cnt_r != LATCH_DELAY) begin
			latch_cnt_r <= latch_cnt_r + 3'h1;
			if (latch_cnt_r == LATCH_DELAY - 3'h1) begin
				unique case (g_s2_r[1:0])
					2'h0: offset_r <= OFFSET_SEL0;
					2'h1: offset_r <= OFFSET_SEL1;
					2'h2: offset_r <= OFFSET_SEL2;
					2'h3: offset_r <= OFFSET_SEL3;
				endcase
			end
		end
	end

	queue_buffer #(.WIDTH(DATA_W), .DEPTH(DEPTH), .LEVEL_W(LEVEL_W)) forward_queue (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
		.i_in_valid(fwd_push), .o_in_ready(fwd_in_ready), .i_in_data(a_data),
		.o_out_valid(fwd_out_valid), .i_out_ready(fwd_pop), .o_out_data(fwd_out_data),
		.o_level(fwd_level)
	);

	queue_buffer #(.WIDTH(DATA_W), .DEPTH(DEPTH), .LEVEL_W(LEVEL_W)) reverse_queue (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
		.i_in_valid(rev_push), .o_in_ready(rev_in_ready), .i_in_data(rev_in_data),
		.o_out_valid(rev_out_valid), .i_out_ready(rev_pop), .o_out_data(rev_out_data),
		.o_level(rev_level)
	);

	// Port one transfers
	assign mail_one_wr = a_go & a_wr & a_mbx & o_mail_one_flag;
	assign mail_two_rd = a_go & ~a_wr & a_mbx;
	assign fwd_push = a_go & a_wr & ~a_mbx & o_side_one_full_flag;
	assign a_q_rd = a_go & ~a_wr & ~a_mbx & o_side_one_empty_flag & rev_out_valid;
	assign rev_pop = a_q_rd;

	// Port two: width and endian lanes follow the settings seen at this edge; swap is applied at the last write piece and the first read piece
	assign b_last_wr = (b_size == SIZE_LONG) | (b_size == SIZE_HALF && b_wr_idx_r != 2'h0) |
		(b_size == SIZE_BYTE && b_wr_idx_r == 2'h3);
	assign b_last_rd = (b_size == SIZE_LONG) | (b_size == SIZE_HALF && b_rd_idx_r != 2'h0) |
		(b_size == SIZE_BYTE && b_rd_idx_r == 2'h3);
	assign b_first_rd = b_rd_idx_r == 2'h0;
	assign mail_two_wr = b_go & b_wr & (b_size == SIZE_MAIL) & o_mail_two_flag;
	assign mail_one_rd = b_go & ~b_wr & (b_size == SIZE_MAIL);
	assign rev_push = b_go & b_wr & (b_size != SIZE_MAIL) & b_last_wr & o_side_two_full_flag;
	assign rev_in_data = swap_word(b_asm_nxt, b_swap);
	assign b_piece_rd = b_go & ~b_wr & (b_size != SIZE_MAIL) &
		(~b_first_rd | (o_side_two_empty_flag & fwd_out_valid));
	assign b_q_rd = b_piece_rd & b_first_rd;
	assign fwd_pop = b_q_rd;

	// Gather pieces; low endian select takes the upper lanes and the first piece lands high
	always_comb begin
		b_asm_nxt = b_data;
		unique case (b_size)
			SIZE_HALF: b_asm_nxt = b_endian ? {b_data[17:0], b_asm_r[35:18]} :
				{b_asm_r[17:0], b_data[35:18]};
			SIZE_BYTE: b_asm_nxt = b_endian ? {b_data[8:0], b_asm_r[35:9]} :
				{b_asm_r[26:0], b_data[35:27]};
			SIZE_LONG, SIZE_MAIL: b_asm_nxt = b_data;
		endcase
	end

	// Split a stored word into pieces on the lanes the endian select names
	always_comb begin
		logic [DATA_W-1:0] word;
		word = b_first_rd ? swap_word(fwd_out_data, b_swap) : b_hold_r;
		b_rd_out = word;
		b_hold_nxt = word;
		unique case (b_size)
			SIZE_HALF: begin
				b_rd_out = b_endian ? {18'h0, word[17:0]} : {word[35:18], 18'h0};
				b_hold_nxt = b_endian ? {18'h0, word[35:18]} : {word[17:0], 18'h0};
			end
			SIZE_BYTE: begin
				b_rd_out = b_endian ? {27'h0, word[8:0]} : {word[35:27], 27'h0};
				b_hold_nxt = b_endian ? {9'h0, word[35:9]} : {word[26:0], 9'h0};
			end
			SIZE_LONG, SIZE_MAIL: begin
				b_rd_out = word;
				b_hold_nxt = word;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			b_wr_idx_r <= '0;
			b_rd_idx_r <= '0;
			b_asm_r <= '0;
			b_hold_r <= '0;
		end else begin
			if (b_go && b_wr && b_size != SIZE_MAIL) begin
				b_asm_r <= b_asm_nxt;
				b_wr_idx_r <= b_last_wr ? 2'h0 : b_wr_idx_r + 2'h1;
			end
			if (b_piece_rd) begin
				b_hold_r <= b_hold_nxt;
				b_rd_idx_r <= b_last_rd ? 2'h0 : b_rd_idx_r + 2'h1;
			end
		end
	end

	// Mailboxes; flag low means unread mail is waiting
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mail_one_r <= '0;
			mail_two_r <= '0;
			o_mail_one_flag <= 1'b1;
			o_mail_two_flag <= 1'b1;
		end else begin
			if (mail_one_wr) begin
				mail_one_r <= a_data;
			end
			if (mail_two_wr) begin
				mail_two_r <= b_data;
			end
			if (mail_one_wr) begin
				o_mail_one_flag <= 1'b0;
			end else if (mail_one_rd) begin
				o_mail_one_flag <= 1'b1;
			end
			if (mail_two_wr) begin
				o_mail_two_flag <= 1'b0;
			end else if (mail_two_rd) begin
				o_mail_two_flag <= 1'b1;
			end
		end
	end

	// Output registers and drivers; drivers are on only while selected and reading
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_side_one_bus <= '0;
			o_side_two_bus <= '0;
			o_side_one_bus_oe_n <= 1'b1;
			o_side_two_bus_oe_n <= 1'b1;
		end else begin
			o_side_one_bus_oe_n <= a_sel_n | a_wr;
			o_side_two_bus_oe_n <= b_sel_n | b_wr;
			if (mail_two_rd) begin
				o_side_one_bus <= a_pg ? gen_parity(mail_two_r, odd) : mail_two_r;
			end else if (a_q_rd) begin
				o_side_one_bus <= a_pg ? gen_parity(rev_out_data, odd) : rev_out_data;
			end
			if (mail_one_rd) begin
				o_side_two_bus <= b_pg ? gen_parity(mail_one_r, odd) : mail_one_r;
			end else if (b_piece_rd) begin
				o_side_two_bus <= b_pg ? gen_parity(b_rd_out, odd) : b_rd_out;
			end
		end
	end

	// Parity checking only reports; it gates no transfer
	always_comb begin
		unique case (b_size)
			SIZE_HALF: b_lane_mask = b_endian ? 4'h3 : 4'hC;
			SIZE_BYTE: b_lane_mask = b_endian ? 4'h1 : 4'h8;
			SIZE_LONG, SIZE_MAIL: b_lane_mask = 4'hF;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_side_one_parity_err_n <= 1'b1;
			o_side_two_parity_err_n <= 1'b1;
		end else begin
			o_side_one_parity_err_n <= ~(|parity_fail(a_data, odd)) | (~a_wr & a_mbx & a_pg);
			o_side_two_parity_err_n <= ~(|(parity_fail(b_data, odd) & b_lane_mask));
		end
	end

	// Flags pass two stages clocked by the owning port edge, so they start low
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			a_flag_s1_r <= '0;
			{o_side_one_full_flag, o_side_one_almost_full, o_side_one_empty_flag, o_side_one_almost_empty} <= '0;
		end else if (a_edge) begin
			a_flag_s1_r <= {fwd_in_ready, (DEPTH_COUNT - fwd_level) > offset_r,
				rev_out_valid, rev_level > offset_r};
			{o_side_one_full_flag, o_side_one_almost_full, o_side_one_empty_flag, o_side_one_almost_empty}
				<= a_flag_s1_r;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			b_flag_s1_r <= '0;
			{o_side_two_full_flag, o_side_two_almost_full, o_side_two_empty_flag, o_side_two_almost_empty} <= '0;
		end else if (b_edge) begin
			b_flag_s1_r <= {rev_in_ready, (DEPTH_COUNT - rev_level) > offset_r,
				fwd_out_valid, fwd_level > offset_r};
			{o_side_two_full_flag, o_side_two_almost_full, o_side_two_empty_flag, o_side_two_almost_empty}
				<= b_flag_s1_r;
		end
	end

	a_queue_depth: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		fwd_level <= DEPTH_COUNT && rev_level <= DEPTH_COUNT) else $error("queue level above depth");
	a_push_on_edge: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		(fwd_push || rev_push) |-> (a_edge || b_edge)) else $error("push outside a port clock edge");
	a_select_gate: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		(fwd_push || rev_pop || mail_one_wr) |-> !a_s2_r[40]) else $error("port one moved while deselected");
	a_enable_gate: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		(fwd_push || rev_pop) |-> a_s2_r[39]) else $error("port one moved while disabled");
	a_drive_off: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		a_s2_r[40] |=> o_side_one_bus_oe_n) else $error("port one driving while deselected");
	a_full_stage: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		$rose(o_side_one_full_flag) |-> $past(a_edge) && $past(a_flag_s1_r[3])) else $error("full flag skipped stage");
	a_empty_two_edges: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		$rose(o_side_two_empty_flag) |-> $past(b_edge) && $past(fwd_out_valid, 2)) else $error("empty flag rose early");
	a_mail_flag: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		mail_one_wr |=> !o_mail_one_flag && mail_one_r == $past(a_data)) else $error("mail one not stored");
	a_almost_empty: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		b_edge && b_flag_s1_r[0] |=> o_side_two_almost_empty) else $error("almost empty not passed on");
	a_parity_gen: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		a_q_rd && a_pg |=> o_side_one_bus == gen_parity($past(rev_out_data), $past(odd))) else $error("bad generated parity");
	a_byte_lane: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		b_piece_rd && b_size == SIZE_BYTE && !b_endian && !b_pg |=> o_side_two_bus[26:0] == 27'h0)
		else $error("byte read off upper lane");

	c_forward_word: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) fwd_push ##[1:200] fwd_pop);
	c_byte_write: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) rev_push && b_size == SIZE_BYTE);
	c_mail_round: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) mail_one_wr ##[1:200] mail_one_rd);
	c_forward_full: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) !fwd_in_ready);
endmodule : dual_clock_bidir_fifo_pair

// >>> hdl/dual_fifo_pkg.sv
// Shared constants and helper functions for the bidirectional queue pair
package dual_fifo_pkg;
	localparam int DATA_W = 36;
	localparam int DEPTH = 64;
	localparam int LEVEL_W = 7;
	localparam int BYTE_W = 9;
	localparam int HALF_W = 18;
	localparam int NBYTES = 4;
	// Preset almost-empty / almost-full offsets, chosen by the two offset selects
	localparam logic [LEVEL_W-1:0] OFFSET_SEL0 = 7'h10;
	localparam logic [LEVEL_W-1:0] OFFSET_SEL1 = 7'h0C;
	localparam logic [LEVEL_W-1:0] OFFSET_SEL2 = 7'h08;
	localparam logic [LEVEL_W-1:0] OFFSET_SEL3 = 7'h04;
	localparam logic [LEVEL_W-1:0] DEPTH_COUNT = 7'h40;
	// Port two transfer size codes; the last one selects the mailbox
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_BYTE = 2'h2;
	localparam logic [1:0] SIZE_MAIL = 2'h3;
	// Byte-order swap modes on port two
	localparam logic [1:0] SWAP_NONE = 2'h0;
	localparam logic [1:0] SWAP_REVERSE = 2'h1;
	localparam logic [1:0] SWAP_HALVES = 2'h2;
	localparam logic [1:0] SWAP_PAIRS = 2'h3;
	// Pipeline reset value: select inactive, all else low
	localparam logic [41:0] SIDE_ONE_SYNC_RST = 42'h100_0000_0000;
	localparam logic [45:0] SIDE_TWO_SYNC_RST = 46'h1000_0000_0000;
	localparam logic [2:0] LATCH_DELAY = 3'h4;

	// Every swap mode is its own inverse, so it serves both directions
	function automatic logic [DATA_W-1:0] swap_word(input logic [DATA_W-1:0] w, input logic [1:0] mode);
		logic [DATA_W-1:0] r;
		r = w;
		unique case (mode)
			SWAP_NONE: r = w;
			SWAP_REVERSE: r = {w[8:0], w[17:9], w[26:18], w[35:27]};
			SWAP_HALVES: r = {w[17:0], w[35:18]};
			SWAP_PAIRS: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
		endcase
		return r;
	endfunction : swap_word

	// Replace the top bit of each byte with generated parity
	function automatic logic [DATA_W-1:0] gen_parity(input logic [DATA_W-1:0] w, input logic odd);
		logic [DATA_W-1:0] r;
		r = w;
		for (int i = 0; i < NBYTES; i++) begin
			r[i*BYTE_W+8] = (^w[i*BYTE_W +: 8]) ^ odd;
		end
		return r;
	endfunction : gen_parity

	// One bit per byte lane that fails the selected parity
	function automatic logic [NBYTES-1:0] parity_fail(input logic [DATA_W-1:0] w, input logic odd);
		logic [NBYTES-1:0] r;
		r = '0;
		for (int i = 0; i < NBYTES; i++) begin
			r[i] = (^w[i*BYTE_W +: BYTE_W]) != odd;
		end
		return r;
	endfunction : parity_fail
endpackage : dual_fifo_pkg

// >>> hdl/queue_buffer.sv
// Single-clock first-in first-out buffer with valid/ready on both sides and a fill level
`timescale 1ns/1ps
module queue_buffer #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8,
	parameter int LEVEL_W = 4
) (
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data,
	output logic [LEVEL_W-1:0] o_level
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [LEVEL_W-1:0] FULL_LEVEL = LEVEL_W'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [LEVEL_W-1:0] level_r;
	logic push;
	logic pop;

	assign o_in_ready = level_r != FULL_LEVEL;
	assign o_out_valid = level_r != '0;
	assign o_out_data = mem_r[rd_ptr_r];
	assign o_level = level_r;
	assign push = i_in_valid & o_in_ready;
	assign pop = i_out_ready & o_out_valid;

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= i_in_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			level_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + PTR_W'(1);
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + PTR_W'(1);
			end
			if (push && !pop) begin
				level_r <= level_r + LEVEL_W'(1);
			end else if (pop && !push) begin
				level_r <= level_r - LEVEL_W'(1);
			end
		end
	end
endmodule : queue_buffer

// >>> tb/port_host.sv
// Host model for one port: free-running port clock and transfer cycles
`timescale 1ns/1ps
module port_host #(
	parameter int HALF = 4
) (
	input wire logic i_core_clk,
	input wire logic [35:0] i_rdata,
	output logic o_clk,
	output logic o_sel_n,
	output logic o_en,
	output logic o_wr,
	output logic o_mb,
	output logic [35:0] o_data
);
	int cnt = 0;
	initial begin
		o_clk = 1'b0;
		o_sel_n = 1'b1;
		o_en = 1'b0;
		o_wr = 1'b1;
		o_mb = 1'b0;
		o_data = '0;
	end
	// Port clock changes only on core falling edges
	always @(negedge i_core_clk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1) o_clk <= ~o_clk;
	end
	// Released bus shows the inverse so stale data is never mistaken for an answer
	task automatic xfer(input logic sel, input logic en, input logic wr, input logic mb,
		input logic [35:0] d, output logic [35:0] q);
		@(negedge o_clk);
		o_sel_n = ~sel;
		o_en = en;
		o_wr = wr;
		o_mb = mb;
		o_data = d;
		@(negedge o_clk);
		o_sel_n = 1'b1;
		o_en = 1'b0;
		o_data = ~d;
		@(negedge o_clk);
		q = i_rdata;
	endtask : xfer
endmodule : port_host

// >>> tb/tb_dual_clock_bidir_fifo_pair.sv
// Self-checking bench for the bidirectional queue pair
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module tb_dual_clock_bidir_fifo_pair;
	import dual_fifo_pkg::*;
	localparam logic [35:0] W = {9'h123, 9'h045, 9'h067, 9'h189};
	localparam int OFS = int'(OFFSET_SEL3);
	localparam int OFS0 = int'(OFFSET_SEL0);
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic c1, s1, e1, w1, m1, c2, s2, e2, w2, oe1, oe2;
	logic ff1, af1, ef1, ae1, ff2, af2, ef2, ae2, mf1, mf2, pe1, pe2;
	logic [35:0] d1, d2, q1, q2, q, x;
	logic [1:0] size = SIZE_LONG;
	logic [1:0] swap = SWAP_NONE;
	logic endian = 1'b0;
	logic pg2 = 1'b0;
	logic pg1 = 1'b0;
	logic [1:0] fsel = 2'h3;
	logic odd = 1'b0;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	always #12.5 clk = ~clk;
	port_host #(.HALF(4)) host_one (.i_core_clk(clk), .i_rdata(q1), .o_clk(c1), .o_sel_n(s1), .o_en(e1),
		.o_wr(w1), .o_mb(m1), .o_data(d1));
	port_host #(.HALF(5)) host_two (.i_core_clk(clk), .i_rdata(q2), .o_clk(c2), .o_sel_n(s2), .o_en(e2),
		.o_wr(w2), .o_mb(), .o_data(d2));
	dual_clock_bidir_fifo_pair dual_clock_bidir_fifo_pair_inst (.i_core_clk(clk), .i_arst_n(arst_n),
		.i_side_one_clock(c1), .i_side_one_select_n(s1), .i_side_one_enable(e1), .i_side_one_write(w1),
		.i_side_one_mailbox(m1), .i_side_one_parity_gen(pg1), .i_side_one_bus(d1), .o_side_one_bus(q1),
		.o_side_one_bus_oe_n(oe1), .i_side_two_clock(c2), .i_side_two_select_n(s2), .i_side_two_enable(e2),
		.i_side_two_write(w2), .i_side_two_size(size), .i_side_two_swap(swap), .i_endian_select(endian),
		.i_side_two_parity_gen(pg2), .i_side_two_bus(d2), .o_side_two_bus(q2), .o_side_two_bus_oe_n(oe2),
		.i_odd_even(odd), .i_offset_select_lo(fsel[0]), .i_offset_select_hi(fsel[1]),
		.o_side_one_full_flag(ff1), .o_side_one_almost_full(af1), .o_side_one_empty_flag(ef1),
		.o_side_one_almost_empty(ae1), .o_side_two_full_flag(ff2), .o_side_two_almost_full(af2),
		.o_side_two_empty_flag(ef2), .o_side_two_almost_empty(ae2), .o_mail_one_flag(mf1),
		.o_mail_two_flag(mf2), .o_side_one_parity_err_n(pe1), .o_side_two_parity_err_n(pe2));
	task automatic finish_test;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	task automatic settle;
		repeat (30) @(negedge clk);
	endtask : settle
	task automatic wr1(input logic [35:0] d);
		host_one.xfer(1'b1, 1'b1, 1'b1, 1'b0, d, q);
	endtask : wr1
	task automatic rd2(output logic [35:0] r);
		host_two.xfer(1'b1, 1'b1, 1'b0, 1'b0, '0, r);
	endtask : rd2
	task automatic t_ignore;
		host_one.xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'h1, q);
		host_one.xfer(1'b1, 1'b0, 1'b1, 1'b0, 36'h2, q);
		settle();
		`CHK(ef2, 1'b0)
		fork
			host_one.xfer(1'b1, 1'b1, 1'b0, 1'b0, '0, q);
			begin
				@(negedge s1);
				repeat (5) @(negedge clk);
				`CHK(oe1, 1'b0)
			end
		join
		`CHK(oe1, 1'b1)
	endtask : t_ignore
	task automatic t_fill;
		for (int i = 0; i <= DEPTH; i++) begin
			wr1({4{9'(i)}});
			settle();
			if (i == 0) `CHK(ef2, 1'b1)
			if (i == OFS - 1 || i == OFS) `CHK(ae2, i == OFS)
			if (i == DEPTH - OFS - 2 || i == DEPTH - OFS - 1) `CHK(af1, i == DEPTH - OFS - 2)
			if (i >= DEPTH - 1) `CHK(ff1, 1'b0)
		end
		for (int i = 0; i < DEPTH; i++) begin
			rd2(q);
			`CHK(q, {4{9'(i)}})
		end
		settle();
		`CHK({ef2, ff1}, 2'b01)
	endtask : t_fill
	task automatic t_swap;
		logic [35:0] e [4];
		e[0] = W;
		e[1] = {W[8:0], W[17:9], W[26:18], W[35:27]};
		e[2] = {W[17:0], W[35:18]};
		e[3] = {W[26:18], W[35:27], W[8:0], W[17:9]};
		for (int m = 0; m < 4; m++) begin
			swap = 2'(m);
			wr1(W);
			settle();
			rd2(q);
			`CHK(q, e[m])
		end
		swap = SWAP_NONE;
	endtask : t_swap
	task automatic t_size;
		for (int e = 0; e < 2; e++) begin
			endian = e[0];
			size = SIZE_BYTE;
			wr1(W);
			settle();
			for (int k = 0; k < 4; k++) begin
				rd2(q);
				x = e[0] ? {27'h0, W[9*k +: 9]} : {W[35-9*k -: 9], 27'h0};
				`CHK(q, x)
			end
		end
		size = SIZE_HALF;
		host_two.xfer(1'b1, 1'b1, 1'b1, 1'b0, {18'h0, W[17:0]}, q);
		host_two.xfer(1'b1, 1'b1, 1'b1, 1'b0, {18'h0, W[35:18]}, q);
		settle();
		host_one.xfer(1'b1, 1'b1, 1'b0, 1'b0, '0, q);
		`CHK(q, W)
		size = SIZE_BYTE;
		endian = 1'b0;
		for (int k = 0; k < 4; k++) begin
			host_two.xfer(1'b1, 1'b1, 1'b1, 1'b0, {W[35-9*k -: 9], 27'h0}, q);
		end
		settle();
		host_one.xfer(1'b1, 1'b1, 1'b0, 1'b0, '0, q);
		`CHK(q, W)
		size = SIZE_HALF;
		wr1(W);
		settle();
		rd2(q);
		`CHK(q, {W[35:18], 18'h0})
		rd2(q);
		`CHK(q, {W[17:0], 18'h0})
		size = SIZE_LONG;
		endian = 1'b0;
	endtask : t_size
	task automatic t_mail;
		host_one.xfer(1'b1, 1'b1, 1'b1, 1'b1, W, q);
		settle();
		`CHK({mf1, ef2}, 2'b00)
		size = SIZE_MAIL;
		rd2(q);
		`CHK({mf1, q}, {1'b1, W})
		host_two.xfer(1'b1, 1'b1, 1'b1, 1'b0, ~W, q);
		settle();
		`CHK(mf2, 1'b0)
		host_one.xfer(1'b1, 1'b1, 1'b0, 1'b1, '0, q);
		`CHK({mf2, q}, {1'b1, ~W})
		size = SIZE_LONG;
	endtask : t_mail
	task automatic t_parity;
		odd = 1'b1;
		pg1 = 1'b1;
		pg2 = 1'b1;
		wr1(36'h0);
		settle();
		`CHK(pe1, 1'b1)
		rd2(q);
		`CHK(q, 36'h8_0402_0100)
		host_two.xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0, q);
		settle();
		host_one.xfer(1'b1, 1'b1, 1'b0, 1'b0, '0, q);
		`CHK(q, 36'h8_0402_0100)
		odd = 1'b0;
		repeat (4) @(negedge clk);
		`CHK({pe1, pe2}, 2'b00)
		pg1 = 1'b0;
		pg2 = 1'b0;
	endtask : t_parity
	// Second reset with another offset choice
	task automatic t_offset;
		arst_n = 1'b0;
		fsel = 2'h0;
		repeat (12) @(negedge clk);
		`CHK({ff1, ef2, mf1, oe1, oe2}, 5'h07)
		arst_n = 1'b1;
		repeat (40) @(negedge clk);
		`CHK({ff1, ff2, ae2}, 3'b110)
		for (int i = 0; i <= OFS0; i++) begin
			wr1(W);
			if (i >= OFS0 - 1) begin
				settle();
				`CHK(ae2, i == OFS0)
			end
		end
	endtask : t_offset
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (6) @(negedge clk);
		`CHK({ff1, ef1, ff2, ef2, mf1, mf2, pe1, oe1, oe2}, 9'h01F)
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		repeat (40) @(negedge clk);
		`CHK({ff1, ff2, ef1, ef2, ae1, ae2, af1, af2}, 8'hC3)
		t_ignore();
		t_fill();
		t_swap();
		t_size();
		t_mail();
		t_parity();
		t_offset();
		finish_test();
	end
endmodule : tb_dual_clock_bidir_fifo_pair
